// ==== host_msg_pkg.sv ====
package host_msg_pkg;

    // Control characters placed on the host link.
    localparam logic [7:0] CHAR_CR  = 8'h0d;
    localparam logic [7:0] CHAR_CAN = 8'h18;
    localparam logic [7:0] CHAR_STX = 8'h02;
    localparam logic [7:0] CHAR_BEL = 8'h07;

    // Error reporting mode that silences internal error reports.
    localparam logic [1:0] ERR_MODE_SILENT = 2'h2;

    // Buffer geometry between formatter and link.
    localparam int TX_FIFO_DEPTH = 32;
    localparam int TX_WORD_WIDTH = 9;

    // Values that settings and ports take after reset.
    localparam logic RST_ROUTE_SHARED = 1'b0;
    localparam logic RST_TX_VALID     = 1'b0;
    localparam logic [7:0] RST_TX_DATA = 8'h00;

    // Origin of each line offered to the formatter.
    typedef enum logic [2:0] {
        KIND_HOST    = 3'h0,
        KIND_PROGRAM = 3'h1,
        KIND_ERR_HOST = 3'h2,
        KIND_ERR_PROG = 3'h3,
        KIND_CTRL_M  = 3'h4
    } kind_t;

    // One byte of a line, with its origin and end mark.
    typedef struct packed {
        kind_t      kind;
        logic       last;
        logic [7:0] data;
    } msg_t;

    // One byte queued for the link, with its destination port.
    typedef struct packed {
        logic       shared;
        logic [7:0] data;
    } txw_t;

    // Formatter sequencing states.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_PREFIX = 3'h1,
        ST_BODY   = 3'h2,
        ST_TERM   = 3'h3,
        ST_FLUSH  = 3'h4,
        ST_ECHO   = 3'h5,
        ST_DROP   = 3'h6
    } fmt_state_t;

    // True for lines that a controller program produced itself.
    function automatic logic isProgram(input kind_t k);
        return (k == KIND_PROGRAM) || (k == KIND_ERR_PROG);
    endfunction

    // True for error lines; unless silenced, they open with the bell, or the tag lead on tagged program errors.
    function automatic logic isError(input kind_t k);
        return (k == KIND_ERR_HOST) || (k == KIND_ERR_PROG);
    endfunction

endpackage

// ==== host_msg_fifo.sv ====
module host_msg_fifo
    import host_msg_pkg::*;
#(
    parameter int WIDTH = TX_WORD_WIDTH,
    parameter int DEPTH = TX_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // Filling side.
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
    logic [AW-1:0]    wrPtr;        // Next slot to write.
    logic [AW-1:0]    rdPtr;        // Next slot to read.
    logic [AW:0]      count;        // Words held.
    logic             doWr;         // Write accepted this cycle.
    logic             doRd;         // Read accepted this cycle.

    // Full and empty come from the true word count.
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    // Storage is written without reset; contents matter only when counted.
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers wrap at the depth; a flush empties the buffer at once.
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end

endmodule

// ==== host_message_formatter.sv ====
module host_message_formatter
    import host_msg_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Live settings.
    input  wire logic       returnSuppressSetting,
    input  wire logic [1:0] errorReportMode,
    input  wire logic       sharedMemoryAsciiEnable,
    // Echo and tag setting writes and save command.
    input  wire logic       cfgWrite,
    input  wire logic       cfgEcho,
    input  wire logic       cfgTag,
    input  wire logic       saveCmd,
    // Saved echo and tag values from non-volatile storage.
    input  wire logic       nvEcho,
    input  wire logic       nvTag,
    // Values handed to non-volatile storage on save.
    output logic            nvWrite,
    output logic            nvEchoOut,
    output logic            nvTagOut,
    // Settings in force.
    output logic            clearEchoSetting,
    output logic            internalTagSetting,
    // Host receive events.
    input  wire logic       rxCmdValid,
    input  wire logic       rxCmdShared,
    input  wire logic       rxCtrlX,
    // Line bytes from programs and command handler.
    input  wire logic       msgValid,
    input  wire msg_t       msg,
    output logic            msgReady,
    // Formatted byte stream to the host.
    output logic            txValid,
    input  wire logic       txReady,
    output logic [7:0]      txData,
    output logic            txShared
);

    fmt_state_t state;        // Formatter state.
    msg_t       hold;         // Byte taken from the line source.
    logic       holdFull;     // Holding register occupied.
    logic       next_holdFull; // Occupancy for the next cycle.
    logic       consume;      // Formatter uses the held byte.
    kind_t      lineKind;     // Origin of the line in progress.
    logic       needCr;       // Line in progress ends with CR.
    logic       lineOpen;     // Last byte of the line not yet taken.
    logic       ctrlXPending; // Control-X seen, flush not yet done.
    logic       routeShared;  // Port of the most recent command.
    logic       pushValid;    // Byte offered to the buffer.
    logic [7:0] pushByte;     // That byte.
    logic       fifoInReady;  // Buffer has room.
    logic       fifoOutValid; // Buffer holds a byte.
    txw_t       fifoOut;      // Oldest buffered byte.
    logic       fifoOutReady; // Output stage takes that byte.
    logic       flushing;     // Buffer and output stage are cleared.

    // Echo and tag load the saved values at reset and follow writes after.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clearEchoSetting   <= nvEcho;
            internalTagSetting <= nvTag;
        end else if (cfgWrite) begin
            clearEchoSetting   <= cfgEcho;
            internalTagSetting <= cfgTag;
        end
    end

    // A save command copies the settings in force to storage.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvWrite   <= 1'b0;
            nvEchoOut <= 1'b0;
            nvTagOut  <= 1'b0;
        end else begin
            nvWrite <= saveCmd;
            if (saveCmd) begin
                nvEchoOut <= clearEchoSetting;
                nvTagOut  <= internalTagSetting;
            end
        end
    end

    // Responses follow the port that delivered the latest command while sharedMemoryAsciiEnable is set; otherwise the non-shared port.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            routeShared <= RST_ROUTE_SHARED;
        end else if (!sharedMemoryAsciiEnable) begin
            routeShared <= 1'b0;
        end else if (rxCmdValid) begin
            routeShared <= rxCmdShared;
        end
    end

    // A control-X arriving as the flush starts is kept, so set wins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlXPending <= 1'b0;
        end else begin
            ctrlXPending <= rxCtrlX || (ctrlXPending && state != ST_FLUSH);
        end
    end

    // Holding register lets the ready output come from a flip-flop.
    assign next_holdFull = (holdFull && !consume) || (msgValid && msgReady);

    // Take a new byte only while the holding register is free.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            holdFull <= 1'b0;
            msgReady <= 1'b0;
            hold     <= '0;
        end else begin
            holdFull <= next_holdFull;
            msgReady <= !next_holdFull;
            if (msgValid && msgReady) begin
                hold <= msg;
            end
        end
    end

    // Buffer writes and use of the held byte, per state.
    always_comb begin
        pushValid = 1'b0;
        pushByte  = CHAR_CR;
        consume   = 1'b0;
        flushing  = (state == ST_FLUSH);
        case (state)
            ST_IDLE: begin
                // A send-control-M byte becomes one CR on its own.
                if (!ctrlXPending && holdFull && hold.kind == KIND_CTRL_M) begin
                    pushValid = 1'b1;
                    pushByte  = CHAR_CR;
                    consume   = fifoInReady;
                end
            end
            ST_PREFIX: begin
                // Tag lead replaces the bell on program lines; host errors and untagged errors keep the bell.
                pushValid = !ctrlXPending;
                pushByte  = (internalTagSetting && isProgram(lineKind)) ? CHAR_STX : CHAR_BEL;
            end
            ST_BODY: begin
                // Line text passes through unchanged.
                pushValid = !ctrlXPending && holdFull;
                pushByte  = hold.data;
                consume   = pushValid && fifoInReady;
            end
            ST_TERM: begin
                // Closing carriage return of the line.
                pushValid = !ctrlXPending;
                pushByte  = CHAR_CR;
            end
            ST_ECHO: begin
                // Echo is written only into the freshly emptied buffer.
                pushValid = 1'b1;
                pushByte  = CHAR_CAN;
            end
            ST_DROP: begin
                // Discard the rest of an aborted or silenced line.
                consume = holdFull;
            end
            default: begin
                pushValid = 1'b0;
            end
        endcase
    end

    // Line sequencing; a pending control-X preempts any line.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            lineKind <= KIND_HOST;
            needCr   <= 1'b0;
            lineOpen <= 1'b0;
        end else begin
            if (consume && hold.last) begin
                lineOpen <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (ctrlXPending) begin
                        state <= ST_FLUSH;
                    end else if (holdFull && hold.kind != KIND_CTRL_M) begin
                        lineKind <= hold.kind;
                        lineOpen <= 1'b1;
                        // Host replies always close; program lines close
                        // unless suppressed, and tagged ones close anyway.
                        needCr <= !isProgram(hold.kind) || !returnSuppressSetting
                                  || internalTagSetting;
                        if (hold.kind == KIND_ERR_PROG && errorReportMode == ERR_MODE_SILENT) begin
                            state <= ST_DROP;
                        end else if (isError(hold.kind)
                                     || (internalTagSetting && hold.kind == KIND_PROGRAM)) begin
                            state <= ST_PREFIX;
                        end else begin
                            state <= ST_BODY;
                        end
                    end
                end
                ST_PREFIX: begin
                    if (ctrlXPending) begin
                        state <= ST_FLUSH;
                    end else if (fifoInReady) begin
                        state <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (ctrlXPending) begin
                        state <= ST_FLUSH;
                    end else if (consume && hold.last) begin
                        state <= needCr ? ST_TERM : ST_IDLE;
                    end
                end
                ST_TERM: begin
                    if (ctrlXPending) begin
                        state <= ST_FLUSH;
                    end else if (fifoInReady) begin
                        state <= ST_IDLE;
                    end
                end
                ST_FLUSH: begin
                    if (clearEchoSetting) begin
                        state <= ST_ECHO;
                    end else begin
                        state <= lineOpen ? ST_DROP : ST_IDLE;
                    end
                end
                ST_ECHO: begin
                    state <= lineOpen ? ST_DROP : ST_IDLE;
                end
                ST_DROP: begin
                    if (ctrlXPending) begin
                        state <= ST_FLUSH;
                    end else if (!lineOpen || (consume && hold.last)) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Buffer between formatter and link; the link may stall it.
    host_msg_fifo #(
        .WIDTH (TX_WORD_WIDTH),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .flush    (flushing),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .inData   ({routeShared, pushByte}),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    // Output stage refills when it is empty or being taken, except during a flush.
    assign fifoOutReady = !flushing && (!txValid || txReady);

    // Registered link outputs; a flush also drops the staged byte.
    always_ff @(posedge clk) begin
        if (!rst_n || flushing) begin
            txValid  <= RST_TX_VALID;
            txData   <= RST_TX_DATA;
            txShared <= RST_ROUTE_SHARED;
        end else if (fifoOutReady) begin
            txValid <= fifoOutValid;
            if (fifoOutValid) begin
                txData   <= fifoOut.data;
                txShared <= fifoOut.shared;
            end
        end
    end

    // Last byte of a program line leaves the body.
    sequence s_progEnd;
        state == ST_BODY && consume && hold.last && lineKind == KIND_PROGRAM;
    endsequence

    // The flush step followed by the echo step.
    sequence s_flushEcho;
        state == ST_FLUSH && clearEchoSetting ##1 state == ST_ECHO;
    endsequence

    property p_crKept;
        @(posedge clk) disable iff (!rst_n)
        s_progEnd and (needCr && !returnSuppressSetting) |=> state == ST_TERM && pushByte == CHAR_CR;
    endproperty
    a_crKept: assert property (p_crKept) else $error("Program line lost its CR.");

    property p_crDropped;
        @(posedge clk) disable iff (!rst_n)
        s_progEnd and (!needCr) |=> state == ST_IDLE;
    endproperty
    a_crDropped: assert property (p_crDropped) else $error("Suppressed line still closed.");

    property p_hostCr;
        @(posedge clk) disable iff (!rst_n)
        state == ST_BODY && lineKind == KIND_HOST && consume && hold.last |=> state == ST_TERM;
    endproperty
    a_hostCr: assert property (p_hostCr) else $error("Host reply lost its CR.");

    property p_ctrlM;
        @(posedge clk) disable iff (!rst_n)
        state == ST_IDLE && !ctrlXPending && holdFull && hold.kind == KIND_CTRL_M
        |-> pushValid && pushByte == CHAR_CR;
    endproperty
    a_ctrlM: assert property (p_ctrlM) else $error("Control-M did not send CR.");

    property p_echo;
        @(posedge clk) disable iff (!rst_n)
        s_flushEcho |-> pushValid && pushByte == CHAR_CAN && fifoInReady && !fifoOutValid && !txValid;
    endproperty
    a_echo: assert property (p_echo) else $error("Echo not sent on a clean buffer.");

    property p_noEcho;
        @(posedge clk) disable iff (!rst_n)
        state == ST_FLUSH && !clearEchoSetting |=> state != ST_ECHO;
    endproperty
    a_noEcho: assert property (p_noEcho) else $error("Echo sent while disabled.");

    property p_flush;
        @(posedge clk) disable iff (!rst_n)
        rxCtrlX && state != ST_FLUSH && state != ST_ECHO |-> ##[1:2] state == ST_FLUSH ##1 !txValid;
    endproperty
    a_flush: assert property (p_flush) else $error("Control-X did not flush.");

    property p_tagLead;
        @(posedge clk) disable iff (!rst_n)
        state == ST_PREFIX && internalTagSetting && isProgram(lineKind) |-> pushByte == CHAR_STX;
    endproperty
    a_tagLead: assert property (p_tagLead) else $error("Tagged line lacks control-B.");

    property p_tagCr;
        @(posedge clk) disable iff (!rst_n)
        state == ST_BODY && isProgram(lineKind) && internalTagSetting && $stable(internalTagSetting)
        && $past(state) == ST_PREFIX |-> needCr;
    endproperty
    a_tagCr: assert property (p_tagCr) else $error("Tagged line may end without CR.");

    property p_bell;
        @(posedge clk) disable iff (!rst_n)
        state == ST_PREFIX && !isProgram(lineKind) |-> pushByte == CHAR_BEL;
    endproperty
    a_bell: assert property (p_bell) else $error("Host error lacks bell.");

    property p_silent;
        @(posedge clk) disable iff (!rst_n)
        state == ST_IDLE && !ctrlXPending && holdFull && hold.kind == KIND_ERR_PROG
        && errorReportMode == ERR_MODE_SILENT |=> state == ST_DROP && !pushValid;
    endproperty
    a_silent: assert property (p_silent) else $error("Silenced error was reported.");

    property p_save;
        @(posedge clk) disable iff (!rst_n)
        saveCmd |=> nvWrite && nvEchoOut == $past(clearEchoSetting) && nvTagOut == $past(internalTagSetting);
    endproperty
    a_save: assert property (p_save) else $error("Save did not store settings.");

    property p_route;
        @(posedge clk) disable iff (!rst_n)
        rxCmdValid && sharedMemoryAsciiEnable |=> routeShared == $past(rxCmdShared);
    endproperty
    a_route: assert property (p_route) else $error("Reply port not the last command port.");

endmodule

// ==== host_link_model.sv ====
module host_link_model
    import host_msg_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Pacing chosen by the bench.
    input  wire logic       hold,
    input  wire logic       slow,
    // Byte stream from the formatter.
    input  wire logic       txValid,
    output logic            txReady,
    input  wire logic [7:0] txData,
    input  wire logic       txShared
);
    timeunit 1ns;
    timeprecision 1ps;

    txw_t got[$]; // Bytes taken from the link, in arrival order.

    // Ready is withheld while holding and paced at random when slow.
    always_ff @(posedge clk) begin
        if (!rst_n || hold) begin
            txReady <= 1'b0;
        end else begin
            txReady <= slow ? 1'($urandom % 2) : 1'b1;
        end
    end

    // A byte is taken only at an edge where both valid and ready are high.
    always @(posedge clk) begin
        if (rst_n && txValid && txReady) begin
            got.push_back('{txShared, txData});
        end
    end
endmodule

// ==== tb_host_message_formatter.sv ====
module tb_host_message_formatter
    import host_msg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, returnSuppressSetting, sharedMemoryAsciiEnable;
    logic [1:0] errorReportMode;
    logic cfgWrite, cfgEcho, cfgTag, saveCmd, nvEcho, nvTag, nvWrite, nvEchoOut, nvTagOut;
    logic clearEchoSetting, internalTagSetting, rxCmdValid, rxCmdShared, rxCtrlX;
    logic msgValid, msgReady, txValid, txReady, txShared, hold, slow;
    msg_t msg;
    logic [7:0] txData;
    txw_t expq[$];                 // Bytes the host should see.
    logic tagV, supV, routeV;      // Settings mirrored by the bench.
    logic [1:0] modeV;
    int miscompares, nChecks, cyc;

    host_message_formatter u_dut (.clk(clk), .rst_n(rst_n),
        .returnSuppressSetting(returnSuppressSetting), .errorReportMode(errorReportMode),
        .sharedMemoryAsciiEnable(sharedMemoryAsciiEnable), .cfgWrite(cfgWrite), .cfgEcho(cfgEcho),
        .cfgTag(cfgTag), .saveCmd(saveCmd), .nvEcho(nvEcho), .nvTag(nvTag), .nvWrite(nvWrite),
        .nvEchoOut(nvEchoOut), .nvTagOut(nvTagOut), .clearEchoSetting(clearEchoSetting),
        .internalTagSetting(internalTagSetting), .rxCmdValid(rxCmdValid), .rxCmdShared(rxCmdShared),
        .rxCtrlX(rxCtrlX), .msgValid(msgValid), .msg(msg), .msgReady(msgReady), .txValid(txValid),
        .txReady(txReady), .txData(txData), .txShared(txShared));

    host_link_model u_host (.clk(clk), .rst_n(rst_n), .hold(hold), .slow(slow), .txValid(txValid),
        .txReady(txReady), .txData(txData), .txShared(txShared));

    // The clock toggles every half period of 2.5 ns.
    always #2.5 clk = ~clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cuts a hang short as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            close_out();
        end
    end

    // Compares one value with its expectation.
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Loads echo and tag through a one-cycle write pulse.
    task automatic set_cfg(input logic e, input logic t);
        cfgWrite <= 1'b1;
        cfgEcho  <= e;
        cfgTag   <= t;
        @(posedge clk);
        cfgWrite <= 1'b0;
        @(posedge clk);
    endtask

    // Offers one line byte by byte and records the framed bytes to expect.
    task automatic send_line(input kind_t k, input int n);
        int w;
        logic [7:0] d;
        logic prog, drop;
        prog = (k == KIND_PROGRAM) || (k == KIND_ERR_PROG);
        drop = (k == KIND_ERR_PROG) && (modeV == 2'h2);
        if (!drop && (k == KIND_ERR_HOST || (k == KIND_ERR_PROG && !tagV))) begin
            expq.push_back('{routeV, CHAR_BEL});
        end else if (!drop && prog && tagV) begin
            expq.push_back('{routeV, CHAR_STX});
        end
        for (int i = 0; i < n; i++) begin
            d = 8'h41 + 8'($urandom % 26);
            msgValid <= 1'b1;
            msg      <= '{kind: k, last: (i == n - 1), data: d};
            if (!drop && k != KIND_CTRL_M) begin
                expq.push_back('{routeV, d});
            end
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (msgReady !== 1'b1 && w < 500);
            if (w >= 500) begin
                miscompares++;
            end
        end
        msgValid <= 1'b0;
        if (!drop && (!prog || !supV || tagV)) begin
            expq.push_back('{routeV, CHAR_CR});
        end
        @(posedge clk);
    endtask

    // Waits for the expected bytes, then compares count and content.
    task automatic expect_out;
        int w;
        w = 0;
        while (u_host.got.size() < expq.size() && w < 800) begin
            @(posedge clk);
            w++;
        end
        repeat (20) @(posedge clk);
        check(9'(u_host.got.size()), 9'(expq.size()));
        foreach (expq[i]) begin
            if (i < u_host.got.size()) check(u_host.got[i], expq[i]);
        end
        u_host.got.delete();
        expq.delete();
    endtask

    initial begin
        {clk, cfgWrite, cfgEcho, cfgTag, saveCmd, rxCmdValid, rxCmdShared, rxCtrlX} = '0;
        {returnSuppressSetting, sharedMemoryAsciiEnable, errorReportMode, msgValid, msg} = '0;
        {nvEcho, nvTag, hold, slow, tagV, supV, routeV, modeV} = '0;
        rst_n = 1'b0;
        void'($urandom(7720));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // Every line kind under each tag, suppress and error mode choice.
        for (int k = 0; k < 5; k++) for (int t = 0; t < 2; t++) for (int s = 0; s < 4; s++) begin
            supV  = s[0];
            modeV = s[1] ? 2'h2 : ((($urandom % 2) == 0) ? 2'h0 : 2'h3);
            tagV  = t[0];
            returnSuppressSetting   <= supV;
            errorReportMode         <= modeV;
            sharedMemoryAsciiEnable <= !supV;
            slow <= 1'($urandom % 2);
            set_cfg(1'b0, tagV);
            routeV = supV ? 1'b0 : 1'($urandom % 2);
            rxCmdValid  <= 1'b1;
            rxCmdShared <= routeV;
            @(posedge clk);
            rxCmdValid <= 1'b0;
            send_line(kind_t'(k), (k == 4) ? 1 : 1 + $urandom % 4);
            expect_out();
        end
        // Fill the buffer behind a stalled host until input is refused.
        {supV, routeV} = 2'b00;
        fork
            send_line(KIND_HOST, 40);
            begin
                repeat (150) @(posedge clk);
                check(9'(msgReady), 9'h0);
                hold <= 1'b0;
            end
            hold <= 1'b1;
        join
        expect_out();
        // Control-X with echo off and on, pending bytes stuck behind a stall.
        sharedMemoryAsciiEnable <= 1'b0;
        routeV = 1'b0;
        for (int e = 0; e < 2; e++) begin
            set_cfg(e[0], 1'b0);
            check(9'(clearEchoSetting), 9'(e));
            hold <= 1'b1;
            send_line(KIND_HOST, 10);
            expq.delete();
            rxCtrlX <= 1'b1;
            @(posedge clk);
            rxCtrlX <= 1'b0;
            repeat (10) @(posedge clk);
            hold <= 1'b0;
            if (e == 1) expq.push_back('{1'b0, CHAR_CAN});
            expect_out();
        end
        // Save exports the settings; reset restores what storage holds.
        set_cfg(1'b1, 1'b1);
        saveCmd <= 1'b1;
        @(posedge clk);
        saveCmd <= 1'b0;
        #1;
        check({6'h0, nvWrite, nvEchoOut, nvTagOut}, 9'h007);
        nvEcho <= 1'b0;
        nvTag  <= 1'b1;
        rst_n  <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({7'h0, clearEchoSetting, internalTagSetting}, 9'h001);
        close_out();
    end
endmodule
